//--- dv/cbb_tb.sv
// self-checking bench for the compare-and-bit branch unit
`timescale 1ns/100ps
module testbench;
    localparam int CYCLE_CEILING = 20000;
    logic i_ref_clk;
    logic i_rst_n;
    logic i_start;
    logic [7:0] i_opcode, i_byte1, i_byte2, i_byte3;
    logic [16:0] i_pc;
    logic [7:0] i_acc;
    logic [7:0] i_mem_data;
    logic [7:0] mem_val;
    logic o_ready, o_mem_rd, o_done, o_taken, o_carry_flag, o_carry_we, o_decode_miss;
    logic [15:0] o_mem_addr;
    logic [16:0] o_next_pc;
    int fail_count = 0;
    int compares = 0;
    int cycle_count = 0;
    logic [7:0] bad_ops [6] = '{8'h00, 8'h02, 8'h07, 8'h27, 8'hC6, 8'hFF};

    cbb_unit #(.PC_W(17)) dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start),
        .i_opcode(i_opcode), .i_byte1(i_byte1), .i_byte2(i_byte2), .i_byte3(i_byte3),
        .i_pc(i_pc), .i_acc(i_acc), .i_mem_data(i_mem_data), .o_ready(o_ready),
        .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr), .o_done(o_done), .o_taken(o_taken),
        .o_next_pc(o_next_pc), .o_carry_flag(o_carry_flag), .o_carry_we(o_carry_we),
        .o_decode_miss(o_decode_miss));

    // operand byte is valid only in the read cycle; inverse elsewhere exposes late sampling
    assign i_mem_data = o_mem_rd ? mem_val : ~mem_val;

    // free-running reference clock, 100 ns period
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // hang guard: a run far beyond the expected length counts as a failure
    always @(posedge i_ref_clk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == CYCLE_CEILING) begin
            fail_count++;
            $display("[ERR] run_length expected below %0d seen %0d", CYCLE_CEILING, cycle_count);
            tally_and_finish();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_vec(input string what, input logic [16:0] exp, input logic [16:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_vec

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // model one instruction, issue it, and compare every result; poke retries start while busy
    task automatic run_op(input logic [7:0] op, b1, b2, b3, input int pc, acc, mem,
                          input bit poke);
        int len, addr, disp, bitn, nxt, cyc;
        bit is_bit, taken, carry;
        is_bit = (op[7:3] == 5'h05) || (op[7:3] == 5'h07) || (op == 8'hC7);
        len = (op == 8'h06 || op == 8'hC7) ? 4 : 3;
        if (op == 8'h06) addr = {b2, b1};
        else if (op == 8'hC7) addr = {b2[4:0], b1};
        else if (op == 8'h05) addr = 'h100 + b1;
        else if (op == 8'h03 || op[7:3] == 5'h07) addr = 'hFE00 + b1;
        else addr = b1;
        disp = (len == 4) ? $signed(b3) : $signed(b2);
        bitn = (op == 8'hC7) ? b2[7:5] : op[2:0];
        taken = is_bit ? (((mem >> bitn) & 1) == 0) : (acc == mem);
        carry = acc < mem;
        nxt = (pc + len + (taken ? disp : 0)) & 'h1FFFF;
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_opcode <= op;
        i_byte1 <= b1;
        i_byte2 <= b2;
        i_byte3 <= b3;
        i_pc <= pc[16:0];
        i_acc <= acc[7:0];
        mem_val <= mem[7:0];
        @(posedge i_ref_clk);
        i_start <= poke;
        if (poke) i_acc <= ~acc[7:0];
        @(negedge i_ref_clk);
        cyc = 1;
        chk_bit("mem_rd", 1'b1, o_mem_rd);
        chk_vec("mem_addr", 17'(addr), {1'b0, o_mem_addr});
        chk_bit("ready", 1'b0, o_ready);
        while (o_done !== 1'b1 && cyc < 6) begin
            @(posedge i_ref_clk);
            i_start <= 1'b0;
            @(negedge i_ref_clk);
            cyc++;
            if (o_done !== 1'b1) chk_bit("mem_rd", 1'b0, o_mem_rd);
        end
        chk_vec("cycles", 17'((len == 4) ? cbb_pkg::CBB_CYC_LONG : cbb_pkg::CBB_CYC_SHORT),
                17'(cyc));
        chk_bit("taken", taken, o_taken);
        chk_vec("next_pc", 17'(nxt), o_next_pc);
        chk_bit("carry_we", !is_bit, o_carry_we);
        if (!is_bit) chk_bit("carry", carry, o_carry_flag);
    endtask : run_op

    // unsupported opcode: miss pulse one cycle later, no completion, stays ready
    task automatic miss_op(input logic [7:0] op);
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_opcode <= op;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        @(negedge i_ref_clk);
        chk_bit("decode_miss", 1'b1, o_decode_miss);
        chk_bit("ready", 1'b1, o_ready);
        chk_bit("mem_rd", 1'b0, o_mem_rd);
        @(negedge i_ref_clk);
        chk_bit("decode_miss", 1'b0, o_decode_miss);
        chk_bit("done", 1'b0, o_done);
    endtask : miss_op

    // main sequence: reset, worked examples, every opcode with random operands, misses
    initial begin
        logic [7:0] op;
        int acc;
        i_rst_n = 1'b0;
        i_start = 1'b0;
        {i_opcode, i_byte1, i_byte2, i_byte3, i_acc, mem_val} = '0;
        i_pc = '0;
        void'($urandom(95979));
        repeat (15) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk_bit("ready", 1'b1, o_ready);
        chk_bit("done", 1'b0, o_done);
        chk_vec("next_pc", 17'h0, o_next_pc);
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        run_op(8'h04, 8'h55, 8'h0D, 8'h00, 'h1F06, 1, 2, 0);
        run_op(8'h04, 8'h55, 8'h07, 8'h00, 'h1F0C, 3, 2, 0);
        run_op(8'h04, 8'h55, 8'h01, 8'h00, 'h1F12, 2, 2, 1);
        run_op(8'h06, 8'h00, 8'h02, 8'h0F, 'h1F06, 1, 2, 0);
        run_op(8'h06, 8'h00, 8'h02, 8'h01, 'h1F14, 2, 2, 0);
        run_op(8'h28, 8'h10, 8'h3F, 8'h00, 'h0F1D, 0, 'hFE, 0);
        run_op(8'h38, 8'h00, 8'h3F, 8'h00, 'h0F1D, 0, 1, 0);
        run_op(8'hC7, 8'h10, 8'h00, 8'h3F, 'h0F1C, 0, 'hFE, 0);
        run_op(8'hC7, 8'h00, 8'h02, 8'h3F, 'h0F1C, 0, 1, 0);
        $display("worked examples done");
        for (int rep = 0; rep < 20; rep++) begin
            for (int k = 0; k < 21; k++) begin
                if (k < 4) op = (k == 0) ? 8'h04 : (k == 1) ? 8'h05 : (k == 2) ? 8'h03 : 8'h06;
                else if (k < 12) op = 8'h28 + 8'(k - 4);
                else if (k < 20) op = 8'h38 + 8'(k - 12);
                else op = 8'hC7;
                acc = $urandom_range(0, 255);
                run_op(op, 8'($urandom), 8'($urandom), 8'($urandom),
                       (rep == 3) ? 'h1FFFE : $urandom_range(0, 'h1FFFF), acc,
                       ($urandom_range(0, 2) == 0) ? acc : $urandom_range(0, 255),
                       $urandom_range(0, 7) == 0);
            end
        end
        $display("random opcode sweep done");
        foreach (bad_ops[i]) miss_op(bad_ops[i]);
        $display("unsupported opcodes done");
        // reset in mid-instruction: held results clear, the next instruction runs clean
        @(posedge i_ref_clk);
        i_start <= 1'b1;
        i_opcode <= 8'h06;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        i_rst_n <= 1'b0;
        @(negedge i_ref_clk);
        chk_bit("ready", 1'b1, o_ready);
        chk_bit("mem_rd", 1'b0, o_mem_rd);
        chk_vec("next_pc", 17'h0, o_next_pc);
        @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        run_op(8'h04, 8'h55, 8'h01, 8'h00, 'h1F12, 2, 2, 0);
        $display("mid-run reset done");
        tally_and_finish();
    end
endmodule : testbench

//--- rtl/cbb_decode.sv
// opcode decoder: operand address, bit number, length and cycle class
`timescale 1ns/100ps
module cbb_decode (
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_byte1,
    input wire logic [7:0] i_byte2,
    input wire logic [7:0] i_byte3,
    output logic o_valid,
    output logic o_is_bit,
    output logic [15:0] o_addr,
    output logic [2:0] o_bitn,
    output logic [7:0] o_disp,
    output logic [2:0] o_len,
    output logic o_three
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // the address alone picks memory or register space; no extra select
    always_comb begin
        o_valid = 1'b1;
        o_is_bit = 1'b0;
        o_addr = {cbb_pkg::CBB_PAGE0_HI, i_byte1};
        o_bitn = 3'h0;
        o_disp = i_byte2;
        o_len = cbb_pkg::CBB_LEN_SHORT;
        o_three = 1'b0;
        if (i_opcode == cbb_pkg::CBB_OP_EQ_PAGE0) begin
            o_addr = {cbb_pkg::CBB_PAGE0_HI, i_byte1};
        end else if (i_opcode == cbb_pkg::CBB_OP_EQ_PAGE1) begin
            o_addr = {cbb_pkg::CBB_PAGE1_HI, i_byte1};
        end else if (i_opcode == cbb_pkg::CBB_OP_EQ_PAGEFE) begin
            o_addr = {cbb_pkg::CBB_PAGEFE_HI, i_byte1};
        end else if (i_opcode == cbb_pkg::CBB_OP_EQ_LONG) begin
            o_addr = {i_byte2, i_byte1};
            o_disp = i_byte3;
            o_len = cbb_pkg::CBB_LEN_LONG;
            o_three = 1'b1;
        end else if (i_opcode[7:3] == cbb_pkg::CBB_OP_BIT_LOW_BASE) begin
            o_is_bit = 1'b1;
            o_bitn = i_opcode[2:0];
        end else if (i_opcode[7:3] == cbb_pkg::CBB_OP_BIT_FE_BASE) begin
            o_is_bit = 1'b1;
            o_bitn = i_opcode[2:0];
            o_addr = {cbb_pkg::CBB_PAGEFE_HI, i_byte1};
        end else if (i_opcode == cbb_pkg::CBB_OP_BIT_MID) begin
            o_is_bit = 1'b1;
            o_bitn = i_byte2[7:cbb_pkg::CBB_MID_BIT_POS];
            o_addr = {3'h0, i_byte2[cbb_pkg::CBB_MID_HI_W-1:0], i_byte1};
            o_disp = i_byte3;
            o_len = cbb_pkg::CBB_LEN_LONG;
            o_three = 1'b1;
        end else begin
            o_valid = 1'b0;
        end
    end

endmodule : cbb_decode

//--- rtl/cbb_pkg.sv
// constants and types for the compare-and-bit branch unit
//
// Behaviour
// - short compare branch: equal adds length plus displacement, else length only
// - both compare branches set carry when accumulator is below operand, else clear
// - compare branch: 3 bytes 2 cycles short address, 4 bytes 3 cycles long
// - opcode 04H, 05H, 03H pick address pages; others use 06H with both bytes
// - long compare opcode 06H carries low, high address and displacement, 4 bytes
// - long compare takes 3 cycles; equal adds 4 plus displacement, else 4
// - compare operand is memory or register byte, chosen only by its address
// - bit branch picks one of eight bits; zero adds length plus displacement
// - bit branch with tested bit one advances by length only
// - bit number in opcode low bits: 28H low page, 38H FE page; C7H middle
// - C7H addresses below 2000H, third byte packs bit number with high bits
// - middle bit branch: one adds 4, zero adds 4 plus displacement
package cbb_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] CBB_OP_EQ_PAGE0 = 8'h04;
    localparam logic [7:0] CBB_OP_EQ_PAGE1 = 8'h05;
    localparam logic [7:0] CBB_OP_EQ_PAGEFE = 8'h03;
    localparam logic [7:0] CBB_OP_EQ_LONG = 8'h06;
    localparam logic [4:0] CBB_OP_BIT_LOW_BASE = 5'h05; // 28H..2FH, top five bits
    localparam logic [4:0] CBB_OP_BIT_FE_BASE = 5'h07; // 38H..3FH, top five bits
    localparam logic [7:0] CBB_OP_BIT_MID = 8'hC7;

    // ----------------------------------------------------------------
    // address pages and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] CBB_PAGE0_HI = 8'h00;
    localparam logic [7:0] CBB_PAGE1_HI = 8'h01;
    localparam logic [7:0] CBB_PAGEFE_HI = 8'hFE;
    localparam int CBB_MID_BIT_POS = 5; // bit number sits in byte 2 bits 7..5
    localparam int CBB_MID_HI_W = 5; // high address bits in byte 2 bits 4..0

    // ----------------------------------------------------------------
    // lengths and cycle counts
    // ----------------------------------------------------------------
    localparam logic [2:0] CBB_LEN_SHORT = 3'h3;
    localparam logic [2:0] CBB_LEN_LONG = 3'h4;
    localparam int CBB_CYC_SHORT = 2;
    localparam int CBB_CYC_LONG = 3;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CBB_IDLE,
        CBB_FETCH,
        CBB_WAIT,
        CBB_FINISH
    } cbb_state_t;

endpackage : cbb_pkg

//--- rtl/cbb_unit.sv
// compare-and-bit branch execution unit: operand read, flag and next pc
`timescale 1ns/100ps
module cbb_unit #(
    parameter int PC_W = 17
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [7:0] i_opcode,
    input wire logic [7:0] i_byte1,
    input wire logic [7:0] i_byte2,
    input wire logic [7:0] i_byte3,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [7:0] i_acc,
    input wire logic [7:0] i_mem_data,
    output logic o_ready,
    output logic o_mem_rd,
    output logic [15:0] o_mem_addr,
    output logic o_done,
    output logic o_taken,
    output logic [PC_W-1:0] o_next_pc,
    output logic o_carry_flag,
    output logic o_carry_we,
    output logic o_decode_miss
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cbb_pkg::cbb_state_t st;
        logic is_bit;
        logic three;
        logic [2:0] bitn;
        logic [2:0] len;
        logic [7:0] disp;
        logic [15:0] addr;
        logic [PC_W-1:0] pc;
        logic [7:0] acc;
        logic [7:0] opnd;
        logic [PC_W-1:0] npc;
        logic taken;
        logic cy;
        logic cy_we;
        logic miss;
    } cbb_regs_t;

    cbb_regs_t q_q;
    cbb_regs_t q_d;

    logic dec_valid;
    logic dec_is_bit;
    logic [15:0] dec_addr;
    logic [2:0] dec_bitn;
    logic [7:0] dec_disp;
    logic [2:0] dec_len;
    logic dec_three;
    logic accept;

    // sign-extended displacement added to the following instruction's pc
    function automatic logic [PC_W-1:0] cbb_target(input logic [PC_W-1:0] pc,
                                                   input logic [2:0] len,
                                                   input logic [7:0] disp);
        cbb_target = pc + PC_W'(len) + {{(PC_W-8){disp[7]}}, disp};
    endfunction : cbb_target

    // ----------------------------------------------------------------
    // decoder
    // ----------------------------------------------------------------
    cbb_decode u_decode (
        .i_opcode(i_opcode),
        .i_byte1(i_byte1),
        .i_byte2(i_byte2),
        .i_byte3(i_byte3),
        .o_valid(dec_valid),
        .o_is_bit(dec_is_bit),
        .o_addr(dec_addr),
        .o_bitn(dec_bitn),
        .o_disp(dec_disp),
        .o_len(dec_len),
        .o_three(dec_three)
    );

    assign accept = i_start && o_ready;

    // ----------------------------------------------------------------
    // sequencer: start, operand read, optional wait, finish
    // ----------------------------------------------------------------
    // the wait state only pads the long forms to their cycle count
    always_comb begin
        q_d = q_q;
        q_d.miss = 1'b0;
        case (q_q.st)
            cbb_pkg::CBB_IDLE: begin
                if (accept && dec_valid) begin
                    q_d.st = cbb_pkg::CBB_FETCH;
                    q_d.is_bit = dec_is_bit;
                    q_d.three = dec_three;
                    q_d.bitn = dec_bitn;
                    q_d.len = dec_len;
                    q_d.disp = dec_disp;
                    q_d.addr = dec_addr;
                    q_d.pc = i_pc;
                    q_d.acc = i_acc;
                end else if (accept) begin
                    q_d.miss = 1'b1; // unknown opcode is refused, no read
                end
            end
            cbb_pkg::CBB_FETCH: begin
                q_d.opnd = i_mem_data;
                if (q_q.is_bit) begin
                    q_d.taken = ~i_mem_data[q_q.bitn];
                    q_d.cy_we = 1'b0;
                end else begin
                    q_d.taken = (q_q.acc == i_mem_data);
                    q_d.cy = (q_q.acc < i_mem_data);
                    q_d.cy_we = 1'b1;
                end
                q_d.st = q_q.three ? cbb_pkg::CBB_WAIT : cbb_pkg::CBB_FINISH;
            end
            cbb_pkg::CBB_WAIT: begin
                q_d.st = cbb_pkg::CBB_FINISH;
            end
            cbb_pkg::CBB_FINISH: begin
                q_d.st = cbb_pkg::CBB_IDLE;
            end
            default: begin
                q_d.st = cbb_pkg::CBB_IDLE;
            end
        endcase
        // next pc settles one cycle after the read; held until the next read cycle ends or reset clears it
        if (q_q.st == cbb_pkg::CBB_FETCH) begin
            if (q_d.taken) begin
                q_d.npc = cbb_target(q_q.pc, q_q.len, q_q.disp);
            end else begin
                q_d.npc = q_q.pc + PC_W'(q_q.len);
            end
        end
    end

    // ----------------------------------------------------------------
    // register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_ready = (q_q.st == cbb_pkg::CBB_IDLE);
    assign o_mem_rd = (q_q.st == cbb_pkg::CBB_FETCH);
    assign o_mem_addr = q_q.addr;
    assign o_done = (q_q.st == cbb_pkg::CBB_FINISH);
    assign o_taken = q_q.taken;
    assign o_next_pc = q_q.npc;
    assign o_carry_flag = q_q.cy;
    assign o_carry_we = o_done && q_q.cy_we;
    assign o_decode_miss = q_q.miss;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_short_start;
        accept && dec_valid && !dec_three;
    endsequence

    sequence s_long_start;
        accept && dec_valid && dec_three;
    endsequence

    sequence s_eq_done;
        o_done && !q_q.is_bit;
    endsequence

    short_cycle_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_short_start |-> ##1 o_mem_rd ##1 o_done)
        else $error("short form did not finish in two cycles");

    long_cycle_count_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_long_start |-> ##1 o_mem_rd ##1 !o_done ##1 o_done)
        else $error("long form did not finish in three cycles");

    operand_addr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        accept && dec_valid |=> o_mem_rd && o_mem_addr == $past(dec_addr))
        else $error("operand read address wrong");

    page_select_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_opcode == cbb_pkg::CBB_OP_EQ_PAGE1 |-> dec_addr == {8'h01, i_byte1} && !dec_three)
        else $error("page one address wrong");

    long_compare_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_opcode == cbb_pkg::CBB_OP_EQ_LONG |-> dec_addr == {i_byte2, i_byte1}
        && dec_len == 3'h4 && dec_disp == i_byte3)
        else $error("long compare decode wrong");

    eq_target_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_eq_done |-> o_next_pc == (q_q.acc == q_q.opnd ?
        cbb_target(q_q.pc, q_q.len, q_q.disp) : q_q.pc + PC_W'(q_q.len)))
        else $error("compare branch target wrong");

    carry_update_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        s_eq_done |-> o_carry_we && o_carry_flag == (q_q.acc < q_q.opnd))
        else $error("carry not updated from compare");

    bit_test_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && q_q.is_bit |-> o_taken == !q_q.opnd[q_q.bitn] && !o_carry_we)
        else $error("bit branch decision or carry wrong");

    bit_fall_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && q_q.is_bit && q_q.opnd[q_q.bitn] |-> o_next_pc == q_q.pc + PC_W'(q_q.len))
        else $error("bit branch fall-through wrong");

    bit_opcode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_opcode[7:3] == 5'h05 |-> dec_is_bit && dec_bitn == i_opcode[2:0] && !dec_three)
        else $error("low page bit opcode decode wrong");

    mid_bit_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_opcode == 8'hC7 |-> dec_addr < 16'h2000 && dec_bitn == i_byte2[7:5] && dec_three)
        else $error("middle range bit decode wrong");

    // expected next pc from the sampled i_pc and i_byte3; only the branch decision comes from o_taken
    mid_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        accept && i_opcode == 8'hC7 |=> ##2 o_done && o_next_pc == $past(i_pc, 3) + PC_W'(4)
        + (o_taken ? {{(PC_W-8){$past(i_byte3[7], 3)}}, $past(i_byte3, 3)} : PC_W'(0)))
        else $error("middle range bit pc wrong");

    // backward step measured modulo the pc width, so a wrap below zero is still legal
    sext_disp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && o_taken && q_q.disp[7] |->
        PC_W'(q_q.pc + PC_W'(q_q.len) - o_next_pc) == PC_W'(9'h100 - {1'b0, q_q.disp}))
        else $error("negative displacement not sign extended");

endmodule : cbb_unit
